// [dspt_pkg.sv]
// Contract
// - Phase correct counts zero up to TOP, back
// - TOP from fixed, capture or compare A
// - Hold TOP one tick, then count down
// - Mode two clears up, sets down; three inverts
// - Overflow flag set at zero
// - Compare A/capture flag set at TOP when TOP comes from compare A or capture
// - Phase correct loads compare buffers at TOP
// - Fixed TOP masks high compare bits on write
// - Compare flag set when counter equals value
// - Pin driven only when direction selects output
// - Zero gives constant low, TOP constant high
// - Mode one toggles A when A is TOP
// - Codes 8 and 9 are frequency correct
// - Frequency correct loads buffers at zero
// - Frequency correct sets TOP flag at TOP
// - Period twice TOP times prescale division
// - Output mode zero leaves port control
package dspt_pkg;
  // Register map, word aligned
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_CMP_A  = 8'h04;
  localparam logic [7:0]  ADDR_CMP_B  = 8'h08;
  localparam logic [7:0]  ADDR_CAPT   = 8'h0c;
  localparam logic [7:0]  ADDR_COUNT  = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS  = 8'h14;
  // Control field positions
  localparam int          CTRL_WGM_LSB  = 0;
  localparam int          CTRL_COMA_LSB = 4;
  localparam int          CTRL_COMB_LSB = 6;
  localparam int          CTRL_DIRA_BIT = 8;
  localparam int          CTRL_DIRB_BIT = 9;
  localparam int          CTRL_PSC_LSB  = 12;
  // Flag positions
  localparam int          FLAG_OVF  = 0;
  localparam int          FLAG_CMPA = 1;
  localparam int          FLAG_CMPB = 2;
  localparam int          FLAG_CAPT = 3;
  // Fixed TOP values and reset values
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  // Prescaler terminal counts, one less than clocks per tick
  localparam logic [9:0]  PSC_DIV8    = 10'h007;
  localparam logic [9:0]  PSC_DIV64   = 10'h03f;
  localparam logic [9:0]  PSC_DIV256  = 10'h0ff;
  localparam logic [9:0]  PSC_DIV1024 = 10'h3ff;
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Where TOP comes from
  typedef enum logic [2:0] {
    DSPT_TOP_NONE = 3'b001,
    DSPT_TOP_FIX  = 3'b010,
    DSPT_TOP_REG  = 3'b100
  } dspt_topsrc_t;

  // Fixed TOP for codes 1..3, all ones otherwise
  function automatic logic [15:0] dspt_fixed_top(input logic [3:0] wgm);
    case (wgm)
      4'h1:    dspt_fixed_top = TOP_8BIT;
      4'h2:    dspt_fixed_top = TOP_9BIT;
      4'h3:    dspt_fixed_top = TOP_10BIT;
      default: dspt_fixed_top = 16'hffff;
    endcase
  endfunction
endpackage

// [dspt_cfg_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Configuration and status shared between the bus slave and the core
interface dspt_cfg_if;
  logic [15:0] ctrl;        // Control word
  logic [15:0] cmp_a_buf;   // Buffered compare A
  logic [15:0] cmp_b_buf;   // Buffered compare B
  logic [15:0] capt_top;    // Capture TOP, unbuffered
  logic        cnt_wr;      // Counter write strobe
  logic [15:0] cnt_wdata;   // Counter write value
  logic [15:0] count;       // Live counter
  logic [3:0]  flag_set;    // One-cycle flag events
  modport slave (output ctrl, cmp_a_buf, cmp_b_buf, capt_top, cnt_wr, cnt_wdata,
                 input count, flag_set);
  modport core  (input ctrl, cmp_a_buf, cmp_b_buf, capt_top, cnt_wr, cnt_wdata,
                 output count, flag_set);
endinterface
`default_nettype wire

// [dspt_axil_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module dspt_axil_regs
  import dspt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  dspt_cfg_if.slave        cfg
);
  // All slave state in one struct
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] ctrl;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] capt;
    logic [3:0]  flags;
    logic        cnt_wr;
    logic [15:0] cnt_wdata;
  } dspt_regs_t;

  dspt_regs_t st;       // Registered state
  dspt_regs_t next_st;  // Next state

  logic        do_wr;   // Both halves of a write are in
  logic [15:0] wmask;   // Byte lanes as bit mask
  logic [15:0] fmask;   // Fixed-resolution mask
  logic [15:0] wv16;    // Merged write value helper

  // Handshakes: accept each half once, hold until response drains
  assign o_awready = !st.aw_got && !st.bvalid;
  assign o_wready  = !st.w_got && !st.bvalid;
  assign o_arready = !st.rvalid;
  assign o_bvalid  = st.bvalid;
  assign o_bresp   = st.bresp;
  assign o_rvalid  = st.rvalid;
  assign o_rdata   = st.rdata;
  assign o_rresp   = st.rresp;

  assign cfg.ctrl      = st.ctrl;
  assign cfg.cmp_a_buf = st.cmp_a;
  assign cfg.cmp_b_buf = st.cmp_b;
  assign cfg.capt_top  = st.capt;
  assign cfg.cnt_wr    = st.cnt_wr;
  assign cfg.cnt_wdata = st.cnt_wdata;

  // Next state of the slave
  always_comb begin
    next_st        = st;
    next_st.cnt_wr = 1'b0;
    do_wr          = 1'b0;
    wmask          = 16'h0000;
    fmask          = 16'hffff;
    wv16           = 16'h0000;
    // Hardware flag events; set wins over a same-cycle clear below
    if (i_awvalid && o_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = i_wdata;
      next_st.wstrb = i_wstrb;
    end
    if (st.aw_got && st.w_got) begin
      do_wr          = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      wmask          = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
      wv16           = st.wdata[15:0] & wmask;
      if (st.ctrl[CTRL_WGM_LSB +: 4] inside {4'h1, 4'h2, 4'h3}) begin
        fmask = dspt_fixed_top(st.ctrl[CTRL_WGM_LSB +: 4]);
      end
      case (st.awaddr)
        ADDR_CTRL:  next_st.ctrl = (st.ctrl & ~wmask) | wv16;
        ADDR_CMP_A: next_st.cmp_a = ((st.cmp_a & ~wmask) | wv16) & fmask;
        ADDR_CMP_B: next_st.cmp_b = ((st.cmp_b & ~wmask) | wv16) & fmask;
        ADDR_CAPT:  next_st.capt = (st.capt & ~wmask) | wv16;
        ADDR_COUNT: begin
          next_st.cnt_wr    = 1'b1;
          next_st.cnt_wdata = wv16;
        end
        // Write one to clear
        ADDR_FLAGS: next_st.flags = st.flags & ~(st.wdata[3:0] & {4{st.wstrb[0]}});
        default:    next_st.bresp = RESP_SLVERR;
      endcase
    end
    next_st.flags = next_st.flags | cfg.flag_set;
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read mux, data registered
    if (i_arvalid && o_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      case (i_araddr)
        ADDR_CTRL:  next_st.rdata = {16'h0000, st.ctrl};
        ADDR_CMP_A: next_st.rdata = {16'h0000, st.cmp_a};
        ADDR_CMP_B: next_st.rdata = {16'h0000, st.cmp_b};
        ADDR_CAPT:  next_st.rdata = {16'h0000, st.capt};
        ADDR_COUNT: next_st.rdata = {16'h0000, cfg.count};
        ADDR_FLAGS: next_st.rdata = {28'h0000000, st.flags};
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st      <= '0;
      st.ctrl <= CTRL_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// [dspt_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none
// Tick generator: 1, 8, 64, 256 or 1024 clocks per tick, 0 stops
module dspt_prescaler
  import dspt_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_sel,
  output logic            o_tick
);
  typedef struct packed {
    logic [9:0] cnt;
  } dspt_psc_t;

  dspt_psc_t st;       // Divider count
  dspt_psc_t next_st;  // Next count
  logic [9:0] limit;   // Terminal count

  always_comb begin
    next_st = st;
    limit   = 10'h000;
    case (i_sel)
      3'h2:    limit = PSC_DIV8;
      3'h3:    limit = PSC_DIV64;
      3'h4:    limit = PSC_DIV256;
      3'h5:    limit = PSC_DIV1024;
      default: limit = 10'h000;
    endcase
    o_tick = (i_sel != 3'h0) && (i_sel <= 3'h5) && (st.cnt >= limit);
    if (o_tick || i_sel == 3'h0) begin
      next_st.cnt = 10'h000;
    end else begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end

  // Count register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// [dspt_pwm_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module dspt_pwm_timer
  import dspt_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [1:0]  i_port_data,
  output logic [1:0]       o_compare_output,
  output logic [1:0]       o_compare_output_oe_n
);
  dspt_cfg_if cfg ();

  logic tick;  // Timer clock enable

  // Register slave
  dspt_axil_regs u_regs (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .cfg       (cfg.slave)
  );

  // Tick source
  dspt_prescaler u_psc (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_sel  (cfg.ctrl[CTRL_PSC_LSB +: 3]),
    .o_tick (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Core state
  typedef struct packed {
    logic [15:0] count;    // Counter value
    logic        down;     // Counting downward
    logic [15:0] cmp_a;    // Active compare A
    logic [15:0] cmp_b;    // Active compare B
    logic [1:0]  ocr;      // Compare output registers
    logic [1:0]  pin;      // Registered pin levels
    logic [1:0]  pin_oe_n; // Registered enables
  } dspt_core_t;

  dspt_core_t st;       // Registered core
  dspt_core_t next_st;  // Next core

  logic [3:0]   wgm;       // Waveform mode select
  logic [1:0]   com [2];   // Output modes per channel
  logic [1:0]   dir;       // Pin direction bits
  logic         pc_mode;   // Phase correct
  logic         pfc_mode;  // Frequency correct
  logic         dual;      // Any dual-slope mode
  dspt_topsrc_t topsrc;    // TOP source class
  logic [15:0]  top;       // Current TOP
  logic         at_top;    // Counter at TOP
  logic         at_bot;    // Counter at BOTTOM
  logic [1:0]   match;     // Compare equality
  logic [15:0]  cmp [2];   // Active compares
  logic [3:0]   evt;       // Flag events this cycle

  assign wgm      = cfg.ctrl[CTRL_WGM_LSB +: 4];
  assign com[0]   = cfg.ctrl[CTRL_COMA_LSB +: 2];
  assign com[1]   = cfg.ctrl[CTRL_COMB_LSB +: 2];
  assign dir      = {cfg.ctrl[CTRL_DIRB_BIT], cfg.ctrl[CTRL_DIRA_BIT]};
  assign cmp[0]   = st.cmp_a;
  assign cmp[1]   = st.cmp_b;
  assign cfg.count    = st.count;
  assign cfg.flag_set = evt;
  assign o_compare_output      = st.pin;
  assign o_compare_output_oe_n = st.pin_oe_n;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    pc_mode  = wgm inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
    pfc_mode = wgm inside {4'h8, 4'h9};
    dual     = pc_mode || pfc_mode;
    topsrc   = DSPT_TOP_NONE;
    top      = 16'hffff;
    unique case (1'b1)
      wgm inside {4'h1, 4'h2, 4'h3}: begin
        topsrc = DSPT_TOP_FIX;
        top    = dspt_fixed_top(wgm);
      end
      wgm inside {4'h8, 4'ha}: begin
        topsrc = DSPT_TOP_REG;
        top    = cfg.capt_top;
      end
      wgm inside {4'h9, 4'hb}: begin
        topsrc = DSPT_TOP_REG;
        top    = st.cmp_a;
      end
      default: begin
        topsrc = DSPT_TOP_NONE;
        top    = 16'hffff;
      end
    endcase
    at_top = dual && (st.count == top);
    at_bot = dual && (st.count == CNT_RST);
    // a compare above TOP never matches
    match  = {st.count == cmp[1], st.count == cmp[0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, buffers, flags and outputs
  always_comb begin
    next_st = st;
    evt     = 4'h0;
    if (tick && dual) begin
      // TOP held one tick, then down
      if (at_top) begin
        next_st.down  = 1'b1;
        next_st.count = st.count - 16'h0001;
      end else if (at_bot && st.down) begin
        next_st.down  = 1'b0;
        next_st.count = st.count + 16'h0001;
      end else if (st.down) begin
        next_st.count = st.count - 16'h0001;
      end else begin
        next_st.count = st.count + 16'h0001;
      end
      if (at_bot) begin
        evt[FLAG_OVF] = 1'b1;
      end
      if ((pc_mode && at_top) || (pfc_mode && at_bot)) begin
        next_st.cmp_a = cfg.cmp_a_buf;
        next_st.cmp_b = cfg.cmp_b_buf;
      end
      if (at_top && topsrc == DSPT_TOP_REG) begin
        if (wgm inside {4'h9, 4'hb}) begin
          evt[FLAG_CMPA] = 1'b1;
        end else begin
          evt[FLAG_CAPT] = 1'b1;
        end
      end
      evt[FLAG_CMPA] = evt[FLAG_CMPA] | match[0];
      evt[FLAG_CMPB] = match[1];
      for (int ch = 0; ch < 2; ch++) begin
        if (match[ch]) begin
          // clear up / set down, inverted for three
          // zero and TOP give steady levels
          unique case (com[ch])
            // BOTTOM counts as up-slope, so a zero compare stays low
            2'h2:    next_st.ocr[ch] = (st.down && !at_bot) || at_top;
            2'h3:    next_st.ocr[ch] = !((st.down && !at_bot) || at_top);
            // toggle A when A is TOP
            2'h1:    next_st.ocr[ch] = (ch == 0 && wgm inside {4'h9, 4'hb}) ? !st.ocr[ch] : st.ocr[ch];
            default: next_st.ocr[ch] = st.ocr[ch];
          endcase
        end
      end
    end else if (!dual) begin
      // Unsupported modes park the counter
      next_st.count = CNT_RST;
      next_st.down  = 1'b0;
      next_st.cmp_a = cfg.cmp_a_buf;
      next_st.cmp_b = cfg.cmp_b_buf;
    end
    // Software write to the counter wins over counting
    if (cfg.cnt_wr) begin
      next_st.count = cfg.cnt_wdata;
    end
    // Pin muxing, registered so pins never glitch
    for (int ch = 0; ch < 2; ch++) begin
      // mode zero or unsupported toggle keeps port control
      if (com[ch] == 2'h0 || (com[ch] == 2'h1 && !(ch == 0 && wgm inside {4'h9, 4'hb}))) begin
        next_st.pin[ch] = i_port_data[ch];
      end else begin
        next_st.pin[ch] = st.ocr[ch];
      end
      next_st.pin_oe_n[ch] = !dir[ch];
    end
  end

  // Core register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st          <= '0;
      st.pin_oe_n <= 2'h3;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// [dspt_pwm_timer_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// Bus and pin checks on the top ports only
module dspt_pwm_timer_asserts
  import dspt_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [1:0]  o_compare_output_oe_n
);
  // One domain; reset silences every check
  default clocking dspt_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////
  // Answers stand until the master takes them
  chk_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response changed before it was taken");
  chk_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data changed before it was taken");
  // No new request while an answer is pending
  chk_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  chk_read_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  // Answer latency from the hand-over walk
  chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  // Sixteen-bit registers, unmapped reads give zero
  chk_upper_zero: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_error_no_data: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0)
    else $error("error read carried data");
  // Drive enable moves only after a control write
  chk_enable_cause: assert property ($changed(o_compare_output_oe_n) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2))
    else $error("drive enable changed without a write");
endmodule

bind dspt_pwm_timer dspt_pwm_timer_asserts i_chk (
  .i_clk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
  .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_compare_output_oe_n
);
`default_nettype wire

// [dspt_load_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Load on the two compare pins, with pull-downs
module dspt_load_model (
  input  wire logic [1:0] i_level,
  input  wire logic [1:0] i_oe_n,
  output logic      [1:0] o_pin
);
  // released pin falls
  // A stale level must never pass for a driven one
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      o_pin[k] = i_oe_n[k] ? 1'b0 : i_level[k];
    end
  end
endmodule
`default_nettype wire

// [tb_dual_slope_pwm_timer16.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_dual_slope_pwm_timer16
  import dspt_pkg::*;
;
  logic        i_clk, i_rst;                  // Clock, reset
  logic [7:0]  i_awaddr, i_araddr;            // Addresses
  logic [31:0] i_wdata, o_rdata;              // Data
  logic [3:0]  i_wstrb;                       // Lanes, all on
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, i_port_data; // Codes, port level
  logic [1:0]  o_compare_output, o_compare_output_oe_n, pin;
  int          miscompares;                   // Mismatches
  int          cmp_count;                     // Comparisons
  int          nd[6] = '{0, 1, 8, 64, 256, 1024};  // Clocks per tick
  // tops at least three, compare within top
  // TOP changed only while stopped, A preferred as TOP
  // Mode, top source (fixed, capture, A), top, mode B, prescale, value (-1 random)
  int          rows[9][6] = '{'{1, 0, 255, 2, 2, -1}, '{2, 0, 511, 3, 1, -1}, '{3, 0, 1023, 2, 1, -1},
                              '{10, 1, 37, 3, 1, -1}, '{11, 2, 29, 2, 1, -1}, '{8, 1, 30, 2, 3, -1},
                              '{9, 2, 3, 3, 1, -1}, '{11, 2, 20, 2, 1, 0}, '{9, 2, 20, 3, 1, 20}};

  dspt_pwm_timer i_dut (
    .i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_port_data, .o_compare_output, .o_compare_output_oe_n
  );
  dspt_load_model i_load (.i_level(o_compare_output), .i_oe_n(o_compare_output_oe_n), .o_pin(pin));

  // 100 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////
  // Verdict, in one place
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_cnt(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // A wait ran out: count it and stop
  task automatic hang(input string nm);
    miscompares++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    report_and_stop();
  endtask

  ////////////////////////////////////////////////////////////
  // Bus write; each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
    end while (o_bvalid !== 1'b1 && n < 200);
    rs = o_bresp;
    i_bready <= 1'b0;
    if (n >= 200) hang("write response");
  endtask

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
    end while (o_rvalid !== 1'b1 && n < 200);
    d = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    if (n >= 200) hang("read data");
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] rs;
    wr(a, d, rs);
    cmp_reg("write response", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(a, d, rs);
    cmp_reg(nm, e, d);
    cmp_reg("read response", {30'h0, er}, {30'h0, rs});
  endtask

  // High cycles and rising edges on one pin, sampled mid-cycle
  task automatic measure(input int ch, input int len, output int hi, output int rise);
    logic prev;
    hi = 0;
    rise = 0;
    @(negedge i_clk);
    prev = pin[ch];
    repeat (len) begin
      @(negedge i_clk);
      if (pin[ch] === 1'b1) hi++;
      if (pin[ch] === 1'b1 && prev === 1'b0) rise++;
      prev = pin[ch];
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int         hi, rise, t, c, nn, p, ex;
    logic [1:0] rs;
    logic [15:0] ctl;
    miscompares = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    {i_awaddr, i_araddr, i_wdata, i_port_data} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_wstrb = 4'hf;
    void'($urandom(67));
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values, unmapped place, read back
    rd_chk("control", ADDR_CTRL, 32'h0, RESP_OKAY);
    rd_chk("counter", ADDR_COUNT, 32'h0, RESP_OKAY);
    rd_chk("unmapped read", 8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 16'hffff, rs);
    cmp_reg("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr_ok(ADDR_CMP_A, 16'h1234);
    rd_chk("compare a", ADDR_CMP_A, 32'h1234, RESP_OKAY);
    for (int m = 1; m < 4; m++) begin
      wr_ok(ADDR_CTRL, 16'(m));
      wr_ok(ADDR_CMP_B, 16'hffff);
      rd_chk("masked compare", ADDR_CMP_B, (32'h1 << (7 + m)) - 1, RESP_OKAY);
    end
    $display("test registers done");
    // Port control with outputs enabled, then released
    wr_ok(ADDR_CTRL, 16'h0300);
    repeat (8) begin
      @(posedge i_clk);
      i_port_data <= 2'($urandom);
      repeat (3) @(negedge i_clk);
      cmp_reg("port level", {30'h0, i_port_data}, {30'h0, pin});
    end
    wr_ok(ADDR_CTRL, 16'h0000);
    repeat (3) @(negedge i_clk);
    cmp_reg("drive enable", 32'h3, {30'h0, o_compare_output_oe_n});
    $display("test port control done");
    // Waveforms: stop in mode 0 so buffers load at once, then run
    foreach (rows[r]) begin
      t = rows[r][2];
      nn = nd[rows[r][4]];
      p = 2 * t * nn;
      c = rows[r][5] < 0 ? 1 + int'($urandom % (t - 1)) : rows[r][5];
      wr_ok(ADDR_CTRL, 16'h0000);
      wr_ok(ADDR_CAPT, 16'(t));
      wr_ok(ADDR_CMP_A, 16'(rows[r][1] == 2 ? t : c));
      wr_ok(ADDR_CMP_B, 16'(c));
      ctl = 16'(rows[r][0] | rows[r][3] << CTRL_COMB_LSB | 32'h200 | rows[r][4] << CTRL_PSC_LSB);
      if (rows[r][1] == 2) ctl = ctl | 16'h0110;
      wr_ok(ADDR_CTRL, ctl);
      wr_ok(ADDR_FLAGS, 16'h000f);
      repeat (2 * p) @(posedge i_clk);
      measure(1, 2 * p, hi, rise);
      ex = rows[r][3] == 2 ? 4 * c * nn : 2 * p - 4 * c * nn;
      cmp_cnt("high time b", ex, hi);
      cmp_cnt("pulses b", (c > 0 && c < t) ? 2 : 0, rise);
      if (rows[r][1] == 2) begin
        measure(0, 2 * p, hi, rise);
        cmp_cnt("high time a", p, hi);
        cmp_cnt("pulses a", 1, rise);
      end
      rd_chk("flags", ADDR_FLAGS, rows[r][1] == 1 ? 32'hf : 32'h7, RESP_OKAY);
      $display("test waveform row %0d done", r);
    end
    // Stopped prescaler holds a loaded counter
    wr_ok(ADDR_CTRL, 16'h0001);
    wr_ok(ADDR_COUNT, 16'h0042);
    repeat (20) @(posedge i_clk);
    rd_chk("held counter", ADDR_COUNT, 32'h42, RESP_OKAY);
    $display("test stopped counter done");
    report_and_stop();
  end
endmodule
`default_nettype wire
